// ---- core/sdce_params.svh ----
// offsets, field positions, reset values and timing counts of the serial dma engine
`ifndef SDCE_PARAMS_SVH
`define SDCE_PARAMS_SVH
`define SDCE_IDX_DLY      12'hF86
`define SDCE_IDX_CTRL     12'hF88
`define SDCE_IDX_COUNT    12'hF90
`define SDCE_IDX_TXPTR    12'hF91
`define SDCE_IDX_RXPTR    12'hF92
`define SDCE_IDX_STAT     12'hF93
`define SDCE_IDX_CFG      12'hF94
`define SDCE_CTRL_RUN     0
`define SDCE_CTRL_DLYINT  1
`define SDCE_CTRL_DUP_LO  2
`define SDCE_CTRL_RXINC   4
`define SDCE_CTRL_TXINC   5
`define SDCE_CTRL_SS_LO   6
`define SDCE_RST_DLY      8'h00
`define SDCE_RST_CTRL     8'h00
`define SDCE_RST_CFG      3'h0
`define SDCE_DUP_FULL     2'h2
`define SDCE_DUP_TX       2'h1
`define SDCE_DUP_RX       2'h0
`define SDCE_DUMMY_TX     8'hFF
`define SDCE_SFR_BANK     4'hE
`define SDCE_CLK_HZ       20000000
`define SDCE_GAP_DIV4     12'h008
`define SDCE_GAP_DIV16    12'h009
`define SDCE_GAP_DIV64    12'h00F
`endif

// ---- core/sdce_pkg.sv ----
// types of the serial dma engine
`default_nettype none
package sdce_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_XFER, ST_UPDATE} sdce_state_t;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } sdce_mem_req_t;
   typedef struct packed {
      logic       load;
      logic [7:0] data;
   } sdce_spi_req_t;
endpackage
`default_nettype wire

// ---- core/sdce_engine.sv ----
// serial port dma engine with avalon register slave
//
// Summary of operation
// - master mode waits base gap 8, 9 or 15 cycles between bytes by divider.
// - delay interrupt off: delay code adds extra gap cycles before buffer write.
// - delay interrupt on: delay times idle interrupt; gap is base plus one.
// - delay code decodes 1..128 powers, 256..896 by 128, 1024, 2048.
// - watermark code 0 completion, 1..32 powers, 67, then 128..576 by 64.
// - 10-bit byte counter decrements after each byte but the last while running.
// - after last byte run bit self-clears and counter reads zero.
// - loaded count N moves exactly N plus one bytes.
// - transmit modes fetch from source pointer, advance it, never write source.
// - transmit fetches never read special banks 14 and 15.
// - receive modes store at destination pointer and advance it.
// - receive stores never modify special banks 14 and 15.
// - irq flag follows watermark and also sets on completion.
// - flag sets when remaining count equals selected level.
// - after watermark fires, only completion, time-out or a write of a level above remaining sets the flag again.
// - watermark writable while running; level above remaining sets flag at once.
// - after that, only another such write, time-out or completion raises it.
// - slave mode delay code may drive an idle time-out interrupt.
// - setup precedes run bit; master starts at once, slave waits for master.
// - direction code 10 full duplex, 01 transmit only, 00 receive only.
// - clearing run mid byte finishes that byte, then stops all updates.
`timescale 1ns/100ps
`include "sdce_params.svh"
`default_nettype none
module sdce_engine
   import sdce_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  wire logic [11:0]   avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   output sdce_spi_req_t      spi_req,
   input  wire logic          spi_byte_done,
   input  wire logic [7:0]    spi_rx_data,
   output sdce_mem_req_t      mem_req,
   input  wire logic [7:0]    mem_rdata,
   output logic               serial_port_irq_flag
);

   function automatic logic [11:0] gap_decode(input logic [3:0] code);
      if (code < 4'h8)
         gap_decode = 12'h001 << code;
      else if (code == 4'hE)
         gap_decode = 12'h400;
      else if (code == 4'hF)
         gap_decode = 12'h800;
      else
         gap_decode = {1'b0, code - 4'h6, 7'h00};
   endfunction

   function automatic logic [10:0] level_decode(input logic [3:0] code);
      if (code == 4'h0)
         level_decode = 11'h000;
      else if (code < 4'h7)
         level_decode = 11'h001 << (code - 4'h1);
      else if (code == 4'h7)
         level_decode = 11'h043;
      else
         level_decode = {1'b0, code - 4'h6, 6'h00};
   endfunction

   function automatic logic in_sfr(input logic [11:0] addr);
      in_sfr = (addr[11:8] >= `SDCE_SFR_BANK);
   endfunction

   sdce_state_t  state;
   logic         ack;
   logic [7:0]   dly_wm;
   logic [1:0]   sscon;
   logic         txinc;
   logic         rxinc;
   logic [1:0]   duplex;
   logic         gap_irq_en;
   logic         run;
   logic         master;
   logic [1:0]   clk_div;
   logic [9:0]   count;
   logic [11:0]  tx_ptr;
   logic [11:0]  rx_ptr;
   logic [7:0]   rx_hold;
   logic [11:0]  gap_cnt;
   logic [11:0]  to_cnt;
   logic         to_fired;
   logic         wm_armed;
   logic         fetch_q;
   logic         wr_en;
   logic         rd_take;
   logic         tx_mode;
   logic         rx_mode;
   logic [11:0]  base_gap;
   logic [11:0]  gap_total;
   logic [11:0]  delay_cyc;
   logic [10:0]  level;
   logic [10:0]  new_level;
   logic         last_byte;
   logic         wm_hit;
   logic         imm_hit;
   logic         done_hit;
   logic         to_hit;
   logic         flag_clr;
   logic [31:0]  next_readdata;

   // one wait cycle per access keeps read data registered
   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign wr_en   = avs_write & ack;
   assign rd_take = avs_read & ~ack;

   assign tx_mode   = (duplex != `SDCE_DUP_RX);
   assign rx_mode   = (duplex != `SDCE_DUP_TX);
   assign delay_cyc = gap_decode(dly_wm[7:4]);
   assign level     = level_decode(dly_wm[3:0]);
   assign new_level = level_decode(avs_writedata[3:0]);
   assign last_byte = (count == 10'h000);

   always_comb begin
      case (clk_div)
         2'h0:    base_gap = `SDCE_GAP_DIV4;
         2'h1:    base_gap = `SDCE_GAP_DIV16;
         default: base_gap = `SDCE_GAP_DIV64;
      endcase
   end

   // gap counted from the completing byte to the next buffer write
   assign gap_total = base_gap + (gap_irq_en ? 12'h001 : delay_cyc);

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         ack <= 1'b0;
      else if (ce)
         ack <= (avs_read | avs_write) & ~ack;
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         `SDCE_IDX_DLY:   next_readdata = {24'h000000, dly_wm};
         `SDCE_IDX_CTRL:  next_readdata = {24'h000000, sscon, txinc, rxinc, duplex, gap_irq_en, run};
         `SDCE_IDX_COUNT: next_readdata = {22'h000000, count};
         `SDCE_IDX_TXPTR: next_readdata = {20'h00000, tx_ptr};
         `SDCE_IDX_RXPTR: next_readdata = {20'h00000, rx_ptr};
         `SDCE_IDX_STAT:  next_readdata = {30'h0, (state != ST_IDLE), serial_port_irq_flag};
         `SDCE_IDX_CFG:   next_readdata = {29'h0, clk_div, master};
         default:         next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (ce && rd_take)
         avs_readdata <= next_readdata;
   end

   // control and configuration registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dly_wm     <= `SDCE_RST_DLY;
         sscon      <= 2'h0;
         txinc      <= 1'b0;
         rxinc      <= 1'b0;
         duplex     <= `SDCE_DUP_RX;
         gap_irq_en <= 1'b0;
         run        <= 1'b0;
         master     <= 1'b0;
         clk_div    <= 2'h0;
      end else if (ce) begin
         if (wr_en && avs_address == `SDCE_IDX_DLY)
            dly_wm <= avs_writedata[7:0];
         if (wr_en && avs_address == `SDCE_IDX_CFG && !run) begin
            master  <= avs_writedata[0];
            clk_div <= avs_writedata[2:1];
         end
         if (wr_en && avs_address == `SDCE_IDX_CTRL) begin
            run <= avs_writedata[`SDCE_CTRL_RUN];
            if (!run) begin
               // other fields frozen mid transaction to protect it
               sscon      <= avs_writedata[`SDCE_CTRL_SS_LO +: 2];
               txinc      <= avs_writedata[`SDCE_CTRL_TXINC];
               rxinc      <= avs_writedata[`SDCE_CTRL_RXINC];
               duplex     <= avs_writedata[`SDCE_CTRL_DUP_LO +: 2];
               // slave select control forces the delay interrupt off
               gap_irq_en <= avs_writedata[`SDCE_CTRL_DLYINT] &
                             (avs_writedata[`SDCE_CTRL_SS_LO +: 2] == 2'h0);
            end
         end
         if (state == ST_UPDATE && last_byte)
            run <= 1'b0;
      end
   end

   // transfer sequencer, counter and pointers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         count   <= 10'h000;
         tx_ptr  <= 12'h000;
         rx_ptr  <= 12'h000;
         rx_hold <= 8'h00;
         gap_cnt <= 12'h000;
         fetch_q <= 1'b0;
         spi_req <= '0;
      end else if (ce) begin
         fetch_q      <= (state == ST_FETCH);
         spi_req.load <= 1'b0;
         if (gap_cnt != 12'h000)
            gap_cnt <= gap_cnt - 12'h001;
         if (wr_en && !run) begin
            if (avs_address == `SDCE_IDX_COUNT)
               count <= avs_writedata[9:0];
            if (avs_address == `SDCE_IDX_TXPTR)
               tx_ptr <= avs_writedata[11:0];
            if (avs_address == `SDCE_IDX_RXPTR)
               rx_ptr <= avs_writedata[11:0];
         end
         case (state)
            ST_IDLE: begin
               gap_cnt <= 12'h000;
               if (run)
                  state <= ST_FETCH;
            end
            ST_FETCH: begin
               state <= run ? ST_LOAD : ST_IDLE;
            end
            ST_LOAD: begin
               if (fetch_q)
                  spi_req.data <= !tx_mode ? `SDCE_DUMMY_TX :
                                  in_sfr(tx_ptr) ? 8'h00 : mem_rdata;
               if (!run)
                  state <= ST_IDLE;
               // slave preloads the buffer and waits for the far master
               else if (!fetch_q && (!master || gap_cnt == 12'h000)) begin
                  spi_req.load <= 1'b1;
                  state        <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (spi_byte_done) begin
                  rx_hold <= spi_rx_data;
                  gap_cnt <= gap_total - 12'h001;
                  state   <= run ? ST_UPDATE : ST_IDLE;
               end
            end
            ST_UPDATE: begin
               // counter and both pointers move in the same cycle
               if (tx_mode && txinc)
                  tx_ptr <= tx_ptr + 12'h001;
               if (rx_mode && rxinc)
                  rx_ptr <= rx_ptr + 12'h001;
               if (last_byte)
                  state <= ST_IDLE;
               else begin
                  count <= count - 10'h001;
                  state <= ST_FETCH;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_comb begin
      mem_req       = '0;
      mem_req.rd    = (state == ST_FETCH) && run && tx_mode && !in_sfr(tx_ptr);
      mem_req.wr    = (state == ST_UPDATE) && rx_mode && !in_sfr(rx_ptr);
      mem_req.addr  = (state == ST_UPDATE) ? rx_ptr : tx_ptr;
      mem_req.wdata = rx_hold;
   end

   // idle time-out counter, armed only by the delay interrupt enable while running
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         to_cnt   <= 12'h000;
         to_fired <= 1'b0;
      end else if (ce) begin
         if (!run || !gap_irq_en || spi_byte_done) begin
            to_cnt   <= 12'h000;
            to_fired <= 1'b0;
         end else if (!to_fired) begin
            to_cnt <= to_cnt + 12'h001;
            if (to_hit)
               to_fired <= 1'b1;
         end
      end
   end

   assign to_hit   = run && gap_irq_en && !spi_byte_done && !to_fired &&
                     (to_cnt == delay_cyc - 12'h001);
   assign wm_hit   = (state == ST_UPDATE) && !last_byte && wm_armed &&
                     (level != 11'h000) && (level == {1'b0, count});
   assign imm_hit  = wr_en && (avs_address == `SDCE_IDX_DLY) && run &&
                     (new_level > ({1'b0, count} + 11'h001));
   assign done_hit = (state == ST_UPDATE) && last_byte;
   assign flag_clr = wr_en && (avs_address == `SDCE_IDX_STAT) && avs_writedata[0];

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wm_armed <= 1'b0;
      end else if (ce) begin
         if (state == ST_IDLE && run)
            wm_armed <= 1'b1;
         else if (wm_hit || imm_hit)
            wm_armed <= 1'b0;
      end
   end

   // a set in the clearing cycle wins
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         serial_port_irq_flag <= 1'b0;
      else if (ce) begin
         if (wm_hit || imm_hit || done_hit || to_hit)
            serial_port_irq_flag <= 1'b1;
         else if (flag_clr)
            serial_port_irq_flag <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !ce);

   gap_min_a: assert property (master && state == ST_XFER && spi_byte_done && run && !last_byte
      |=> !spi_req.load [*8])
      else $error("buffer written before base gap");
   count_dec_a: assert property (state == ST_UPDATE && !last_byte
      |=> count == $past(count) - 10'h001)
      else $error("count did not decrement");
   done_clear_a: assert property (state == ST_UPDATE && last_byte
      |=> !run && serial_port_irq_flag && count == 10'h000)
      else $error("completion did not stop and flag");
   sfr_read_a: assert property (mem_req.rd |-> mem_req.addr[11:8] < `SDCE_SFR_BANK)
      else $error("fetch from special bank");
   sfr_write_a: assert property (mem_req.wr |-> mem_req.addr[11:8] < `SDCE_SFR_BANK)
      else $error("store to special bank");
   tx_advance_a: assert property (state == ST_UPDATE && tx_mode && txinc
      |=> tx_ptr == $past(tx_ptr) + 12'h001)
      else $error("source pointer did not advance");
   rx_store_a: assert property (state == ST_UPDATE && rx_mode && !in_sfr(rx_ptr)
      |-> mem_req.wr && mem_req.addr == rx_ptr && mem_req.wdata == rx_hold)
      else $error("received byte not stored");
   imm_irq_a: assert property (imm_hit |=> serial_port_irq_flag && !wm_armed)
      else $error("level above remaining did not flag");
   abort_stop_a: assert property (state == ST_XFER && spi_byte_done && !run
      |=> state == ST_IDLE && $stable(count) && $stable(tx_ptr))
      else $error("abort still updated state");
   wm_level_a: assert property (wm_hit |=> serial_port_irq_flag && count + 10'h001 == $past(count))
      else $error("watermark flag missing");

endmodule
`default_nettype wire

// ---- test/sdce_partner.sv ----
// serial port and data sram model facing the dma engine
`timescale 1ns/100ps
`default_nettype none
module sdce_partner
   import sdce_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic [3:0]    lat,
   input  wire sdce_spi_req_t spi_req,
   input  wire sdce_mem_req_t mem_req,
   output logic               spi_byte_done,
   output logic [7:0]         spi_rx_data,
   output logic [7:0]         mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] rx_seq = 8'h5A;
   int         wait_cnt = -1;
   initial begin
      spi_byte_done = 1'b0;
      spi_rx_data   = 8'h00;
      mem_rdata     = 8'h00;
   end
   // one cycle read latency; data toggles when not read so stale bytes never match
   always @(posedge sys_clk) begin
      mem_rdata <= mem_req.rd ? mem[mem_req.addr] : ~mem_rdata;
      if (mem_req.wr)
         mem[mem_req.addr] <= mem_req.wdata;
   end
   // byte ends lat plus two cycles after the buffer load pulse; rx line toggles outside that cycle
   always @(posedge sys_clk) begin
      spi_byte_done <= 1'b0;
      spi_rx_data   <= ~spi_rx_data;
      if (spi_req.load)
         wait_cnt <= lat;
      else if (wait_cnt > 0)
         wait_cnt <= wait_cnt - 1;
      else if (wait_cnt == 0) begin
         wait_cnt      <= -1;
         spi_byte_done <= 1'b1;
         spi_rx_data   <= rx_seq;
         rx_seq        <= rx_seq + 8'h3B;
      end
   end
endmodule
`default_nettype wire

// ---- test/sdce_engine_tb.sv ----
// self-checking bench for the serial dma engine
`timescale 1ns/100ps
`include "sdce_params.svh"
`default_nettype none
module sdce_engine_tb
   import sdce_pkg::*;
;
   logic          sys_clk = 1'b0;
   logic          rst_n = 1'b0;
   logic [11:0]   avs_address = 12'h000;
   logic          avs_read = 1'b0;
   logic          avs_write = 1'b0;
   logic [31:0]   avs_writedata = 32'h0;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   sdce_spi_req_t spi_req;
   sdce_mem_req_t mem_req;
   logic          spi_byte_done;
   logic [7:0]    spi_rx_data;
   logic [7:0]    mem_rdata;
   logic          serial_port_irq_flag;
   logic [3:0]    lat = 4'h2;
   logic [1:0]    mode = 2'h0;
   logic          halted = 1'b0;
   logic [31:0]   q;
   logic [11:0]   tx;
   logic [11:0]   rx;
   logic [7:0]    exp_tx [$];
   logic [7:0]    rx_got [$];
   int            bad_count = 0;
   int            n_checks = 0;
   int            seed = 32'h3D17;
   int            cyc = 0;
   int            t_done = 0;
   int            n_done = 0;
   int            n_rise = 0;
   int            rise_at = -1;
   int            exp_gap = -1;
   int            nb;
   int            c0;
   logic          flag_q = 1'b0;
   sdce_engine dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi_req(spi_req),
      .spi_byte_done(spi_byte_done), .spi_rx_data(spi_rx_data), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .serial_port_irq_flag(serial_port_irq_flag));
   sdce_partner p (.sys_clk(sys_clk), .lat(lat), .spi_req(spi_req), .mem_req(mem_req),
      .spi_byte_done(spi_byte_done), .spi_rx_data(spi_rx_data), .mem_rdata(mem_rdata));
   initial forever #25 sys_clk = ~sys_clk;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic int dec_gap(input logic [3:0] c);
      return c < 8 ? 1 << c : c < 14 ? 256 + 128 * (c - 8) : c == 14 ? 1024 : 2048;
   endfunction
   // monitor: gap, sent bytes and every memory access
   always @(posedge sys_clk) begin
      cyc++;
      if (spi_byte_done === 1'b1) begin
         t_done = cyc;
         n_done++;
         rx_got.push_back(spi_rx_data);
      end
      if (serial_port_irq_flag === 1'b1 && flag_q !== 1'b1) begin
         n_rise++;
         if (rise_at < 0)
            rise_at = n_done;
      end
      flag_q = serial_port_irq_flag;
      if (spi_req.load === 1'b1 && exp_tx.size() > 0) begin
         if (exp_gap >= 0 && n_done > 0)
            // load is seen here one edge after the engine launches it
            chk("gap", cyc - t_done - 1, exp_gap);
         chk("tx byte", spi_req.data, exp_tx.pop_front());
      end
      if (mem_req.rd | mem_req.wr) begin
         chk("sfr access", mem_req.addr[11:8] >= 4'hE, 0);
         chk("tx-only write", mem_req.wr && mode == `SDCE_DUP_TX, 0);
         chk("access when stopped", halted, 0);
      end
   end
   // request held until waitrequest is sampled low at a rising edge, released at that edge
   task automatic av(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata;
      chk("waitrequest", avs_waitrequest, 0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic start(input logic [1:0] md, input logic [2:0] cfg, input logic [7:0] dly,
                        input logic ie, input int n);
      int base;
      base = cfg[2:1] == 2'h0 ? 8 : cfg[2:1] == 2'h1 ? 9 : 15;
      mode = md;
      exp_gap = cfg[0] ? base + (ie ? 1 : dec_gap(dly[7:4])) : -1;
      exp_tx.delete();
      rx_got.delete();
      n_done = 0;
      n_rise = 0;
      rise_at = -1;
      lat = 4'(1 + {$random(seed)} % 6);
      for (int i = 0; i <= n; i++)
         exp_tx.push_back(md == `SDCE_DUP_RX ? 8'hFF :
                          12'(tx + i) >= 12'hE00 ? 8'h00 : p.mem[12'(tx + i)]);
      av(1'b1, `SDCE_IDX_DLY, {24'h0, dly});
      av(1'b1, `SDCE_IDX_CFG, {29'h0, cfg});
      av(1'b1, `SDCE_IDX_COUNT, 32'(n));
      av(1'b1, `SDCE_IDX_TXPTR, {20'h0, tx});
      av(1'b1, `SDCE_IDX_RXPTR, {20'h0, rx});
      av(1'b1, `SDCE_IDX_CTRL, {26'h0, 2'h3, md, ie, 1'b1});
   endtask
   task automatic finish(input logic [1:0] md, input int n, input int er);
      q = 32'h1;
      for (int k = 0; k < 8000 && q[0] !== 1'b0; k++)
         av(1'b0, `SDCE_IDX_CTRL, 32'h0);
      chk("run bit", q[0], 0);
      av(1'b0, `SDCE_IDX_COUNT, 32'h0);
      chk("count", q, 0);
      chk("bytes", n_done, n + 1);
      chk("unsent", exp_tx.size(), 0);
      av(1'b0, `SDCE_IDX_STAT, 32'h0);
      chk("flag", q[0], 1);
      if (er >= 0)
         chk("flag rises", n_rise, er);
      av(1'b1, `SDCE_IDX_STAT, 32'h1);
      if (md != `SDCE_DUP_RX) begin
         av(1'b0, `SDCE_IDX_TXPTR, 32'h0);
         chk("tx ptr", q, 12'(tx + n + 1));
      end
      if (md != `SDCE_DUP_TX) begin
         av(1'b0, `SDCE_IDX_RXPTR, 32'h0);
         chk("rx ptr", q, 12'(rx + n + 1));
         for (int i = 0; i <= n; i++)
            if (12'(rx + i) < 12'hE00)
               chk("rx mem", p.mem[12'(rx + i)], rx_got[i]);
      end
   endtask
   initial begin
      #5000000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 4096; i++)
         p.mem[i] = 8'($random(seed));
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      av(1'b0, `SDCE_IDX_DLY, 32'h0);
      chk("dly reset", q, `SDCE_RST_DLY);
      av(1'b0, `SDCE_IDX_CTRL, 32'h0);
      chk("ctrl reset", q, `SDCE_RST_CTRL);
      av(1'b1, 12'h000, 32'hFF);
      av(1'b0, 12'h000, 32'h0);
      chk("unmapped", q, 0);
      // every delay code, mode and divider; one slave run and one run in the sfr banks
      for (int i = 0; i < 20; i++) begin
         nb = {$random(seed)} % 3;
         tx = i == 5 ? 12'hEFE : 12'(12'h100 + 16 * i);
         rx = i == 5 ? 12'hFFE : 12'(12'h400 + 16 * i);
         start(2'(i % 3), {2'((i / 3) % 3), i != 7}, {4'(i), 4'h0}, i >= 16, nb);
         finish(2'(i % 3), nb, i >= 16 ? -1 : 1);
      end
      tx = 12'h300;
      rx = 12'h600;
      start(`SDCE_DUP_FULL, 3'h1, 8'h05, 1'b0, 20);
      for (int k = 0; k < 3000 && serial_port_irq_flag !== 1'b1; k++)
         @(posedge sys_clk);
      av(1'b1, `SDCE_IDX_STAT, 32'h1);
      chk("level reached at", rise_at, 5);
      finish(`SDCE_DUP_FULL, 20, 2);
      start(`SDCE_DUP_FULL, 3'h1, 8'h30, 1'b0, 20);
      for (int k = 0; k < 3000 && n_done < 3; k++)
         @(posedge sys_clk);
      av(1'b1, `SDCE_IDX_DLY, 32'h3F);
      av(1'b0, `SDCE_IDX_STAT, 32'h0);
      chk("early flag", q[0], 1);
      av(1'b1, `SDCE_IDX_STAT, 32'h1);
      finish(`SDCE_DUP_FULL, 20, 2);
      start(`SDCE_DUP_FULL, 3'h1, 8'h00, 1'b0, 10);
      lat <= 4'h5;
      for (int k = 0; k < 3000 && n_done < 2; k++)
         @(posedge sys_clk);
      // abort lands while the third byte is still on the wire
      for (int k = 0; k < 3000 && spi_req.load !== 1'b1; k++)
         @(posedge sys_clk);
      av(1'b1, `SDCE_IDX_CTRL, 32'h38);
      repeat (100) @(posedge sys_clk);
      halted = 1'b1;
      nb = n_done;
      chk("byte in progress", nb, 3);
      av(1'b0, `SDCE_IDX_COUNT, 32'h0);
      c0 = q;
      chk("count at stop", c0, 8);
      av(1'b0, `SDCE_IDX_TXPTR, 32'h0);
      chk("tx ptr at stop", q, 12'(tx + 2));
      repeat (200) @(posedge sys_clk);
      chk("bytes after stop", n_done, nb);
      av(1'b0, `SDCE_IDX_COUNT, 32'h0);
      chk("count after stop", q, c0);
      av(1'b0, `SDCE_IDX_STAT, 32'h0);
      chk("busy", q[1], 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
